// >>> verilog/tio_trigger_strobe.sv
// trigger input conditioning and strobe output driver
// assumes inputs are asynchronous pins, Wishbone master on sys_clk_i
//
// Behaviour
// - each trigger input debounces for 1 to 255 programmed microseconds
// - pulses shorter than the debounce time never produce a trigger
// - a debounce value of zero acts as one microsecond
// - trigger only after input holds past path delay plus debounce time
// - in two-pulse line scan, input 1 starts and input 2 ends frame
// - in two-pulse line scan, input 3 starts and input 4 ends frame
// - each input raises its own interrupt and its level is readable
// - software selects each input as trigger source or plain input
// - a software trigger command acts like a validated trigger
// - per input level setting: differential, TTL, 12 V or 24 V
// - ten outputs, each switchable between static and strobe use
// - each output stays high impedance until its enable is set
// - pulse timing steps are one clock period each
`timescale 1ns/100ps
`default_nettype none
`include "tio_cfg.svh"

module tio_trigger_strobe #(
   parameter int unsigned US_CYCLES = `TIO_US_CYC
) (
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   reset_n_i,
   // wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   // input pins, after the receivers
   input  wire logic [`TIO_N_IN-1:0]   trig_in_i,
   output logic      [2*`TIO_N_IN-1:0] level_sel_o,
   // validated triggers and frames
   output logic      [`TIO_N_IN-1:0]   trig_o,
   output logic      [`TIO_N_PAIR-1:0] frame_active_o,
   // general outputs
   output logic      [`TIO_N_OUT-1:0]  gpo_o,
   output logic      [`TIO_N_OUT-1:0]  gpo_oe_o,
   // interrupt
   output logic                        irq_o
);

   tio_pkg::tio_state_s s;
   tio_pkg::tio_state_s next_s;

   // --------------------------------------------------------------------
   // next state
   // --------------------------------------------------------------------

   // bus, debounce, triggers, interrupts and strobes
   always_comb begin
      logic        acc;
      logic        clr;
      logic [31:0] wm;
      logic [31:0] rv;
      logic [31:0] wv;
      logic [3:0]  idx;
      logic [7:0]  eff;
      logic [15:0] lim;
      logic [1:0]  src;
      logic        go;
      logic [`TIO_N_IN-1:0] ev;
      acc = wb_cyc_i & wb_stb_i & ~s.ack;
      clr = 1'b0;
      wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      rv = `TIO_RST_REG;
      wv = 32'h0000_0000;
      idx = wb_adr_i[5:2];
      eff = 8'h00;
      lim = 16'h0000;
      src = 2'h0;
      go = 1'b0;
      ev = '0;
      next_s = s;

      // two-stage synchroniser on the pins
      next_s.sync1 = trig_in_i;
      next_s.sync2 = s.sync1;
      next_s.ack = 1'b0;
      next_s.sw_pend = '0;

      // read value of the addressed register
      if (wb_adr_i == `TIO_A_CTRL) begin
         rv = {22'h0, s.pair_en, s.edge_fall, s.src_en};
      end else if (wb_adr_i == `TIO_A_LEVEL) begin
         rv = {24'h0, s.lvl};
      end else if (wb_adr_i == `TIO_A_DEBOUNCE) begin
         rv = s.dbv;
      end else if (wb_adr_i == `TIO_A_STATUS) begin
         rv = {28'h0, s.status};
      end else if (wb_adr_i == `TIO_A_MASK) begin
         rv = {28'h0, s.mask};
      end else if (wb_adr_i == `TIO_A_INPUT) begin
         rv = {26'h0, s.frame, s.filt};
      end else if (wb_adr_i[7:6] == `TIO_A_CFG_WIN && idx < 4'(`TIO_N_OUT)) begin
         rv = {25'h0, s.cfg[idx]};
      end else if (wb_adr_i[7:6] == `TIO_A_TIM_WIN && idx < 4'(`TIO_N_OUT)) begin
         rv = s.tim[idx];
      end
      wv = (rv & ~wm) | (wb_dat_i & wm);

      // one-cycle acknowledge, registered read data
      if (acc) begin
         next_s.ack = 1'b1;
         next_s.dat = wb_we_i ? 32'h0000_0000 : rv;
         if (!wb_we_i && wb_adr_i == `TIO_A_STATUS) begin
            clr = 1'b1;
         end
         if (wb_we_i) begin
            if (wb_adr_i == `TIO_A_CTRL) begin
               next_s.src_en = wv[3:0];
               next_s.edge_fall = wv[7:4];
               next_s.pair_en = wv[9:8];
            end else if (wb_adr_i == `TIO_A_LEVEL) begin
               next_s.lvl = wv[7:0];
            end else if (wb_adr_i == `TIO_A_DEBOUNCE) begin
               next_s.dbv = wv;
            end else if (wb_adr_i == `TIO_A_SWTRIG) begin
               next_s.sw_pend = wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0;
            end else if (wb_adr_i == `TIO_A_MASK) begin
               next_s.mask = wv[3:0];
            end else if (wb_adr_i[7:6] == `TIO_A_CFG_WIN && idx < 4'(`TIO_N_OUT)) begin
               next_s.cfg[idx] = wv[6:0];
            end else if (wb_adr_i[7:6] == `TIO_A_TIM_WIN && idx < 4'(`TIO_N_OUT)) begin
               next_s.tim[idx] = wv;
            end
         end
      end

      // debounce filter and edge detection per input
      for (int i = 0; i < `TIO_N_IN; i++) begin
         eff = (s.dbv[i] == 8'h00) ? 8'h01 : s.dbv[i];
         lim = 16'(eff * US_CYCLES);
         if (s.sync2[i] == s.filt[i]) begin
            // a short pulse restarts the count
            next_s.dbc[i] = 16'h0000;
         end else if (s.dbc[i] + 16'h0001 >= lim) begin
            // level held for the whole debounce time
            next_s.filt[i] = s.sync2[i];
            next_s.dbc[i] = 16'h0000;
         end else begin
            next_s.dbc[i] = s.dbc[i] + 16'h0001;
         end
         // chosen edge of the debounced level
         ev[i] = (next_s.filt[i] != s.filt[i]) && (next_s.filt[i] != s.edge_fall[i]);
         next_s.trig[i] = (ev[i] & s.src_en[i]) | s.sw_pend[i];
      end

      // sticky per-input interrupt, set wins over read clear
      next_s.status = (clr ? 4'h0 : s.status) | ev;
      next_s.irq = |(next_s.status & next_s.mask);

      // two-pulse variable length frames
      for (int p = 0; p < `TIO_N_PAIR; p++) begin
         if (!s.pair_en[p]) begin
            next_s.frame[p] = 1'b0;
         end else if (next_s.trig[2*p]) begin
            // first input of the pair opens the frame
            next_s.frame[p] = 1'b1;
         end else if (next_s.trig[2*p+1]) begin
            next_s.frame[p] = 1'b0;
         end
      end

      // strobe sequencers
      for (int j = 0; j < `TIO_N_OUT; j++) begin
         src = s.cfg[j][`TIO_C_SRC_HI:`TIO_C_SRC_LO];
         go = s.trig[src] & s.cfg[j][`TIO_C_STB_EN];
         // one delayed pulse per trigger, retrigger ignored
         case (s.ph[j])
            tio_pkg::ph_idle: begin
               if (go) begin
                  next_s.ph[j] = tio_pkg::ph_delay;
                  next_s.cnt[j] = s.tim[j][15:0];
               end
            end
            tio_pkg::ph_delay: begin
               if (s.cnt[j] == 16'h0000) begin
                  next_s.ph[j] = tio_pkg::ph_pulse;
                  next_s.cnt[j] = s.tim[j][31:16];
               end else begin
                  next_s.cnt[j] = s.cnt[j] - 16'h0001;
               end
            end
            tio_pkg::ph_pulse: begin
               if (s.cnt[j] == 16'h0000) begin
                  next_s.ph[j] = tio_pkg::ph_idle;
               end else begin
                  next_s.cnt[j] = s.cnt[j] - 16'h0001;
               end
            end
            default: begin
               next_s.ph[j] = tio_pkg::ph_idle;
            end
         endcase
         if (!s.cfg[j][`TIO_C_MODE]) begin
            next_s.ph[j] = tio_pkg::ph_idle;
         end
         if (s.cfg[j][`TIO_C_MODE]) begin
            next_s.gpo[j] = (next_s.ph[j] == tio_pkg::ph_pulse) ^ s.cfg[j][`TIO_C_POL];
         end else begin
            next_s.gpo[j] = s.cfg[j][`TIO_C_STATIC];
         end
         next_s.oe[j] = s.cfg[j][`TIO_C_OE];
      end
   end

   // --------------------------------------------------------------------
   // state register
   // --------------------------------------------------------------------

   // all state, cleared by reset
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state
   assign wb_dat_o = s.dat;
   assign wb_ack_o = s.ack;
   assign level_sel_o = s.lvl;
   assign trig_o = s.trig;
   assign frame_active_o = s.frame;
   assign gpo_o = s.gpo;
   assign gpo_oe_o = s.oe;
   assign irq_o = s.irq;

   // --------------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------------

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // effective debounce count of input 0
   logic [15:0] lim0;
   assign lim0 = 16'(((s.dbv[0] == 8'h00) ? 8'h01 : s.dbv[0]) * US_CYCLES);

   // bus accesses taken this cycle
   logic        acc_rd_status;
   logic        acc_wr_level;
   assign acc_rd_status = wb_cyc_i & wb_stb_i & ~s.ack & ~wb_we_i & (wb_adr_i == `TIO_A_STATUS);
   assign acc_wr_level = wb_cyc_i & wb_stb_i & ~s.ack & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TIO_A_LEVEL);

   a_db_full_hold: assert property (
      $changed(s.filt[0]) |-> ($past(s.dbc[0]) + 16'h0001 >= $past(lim0)))
      else $error("debounced level changed early");

   a_db_glitch_drop: assert property (
      (s.sync2[0] == s.filt[0]) |=> (s.dbc[0] == 16'h0000) && $stable(s.filt[0]))
      else $error("glitch not rejected");

   a_db_zero_min: assert property (
      (s.dbv[0] == 8'h00) && $changed(s.filt[0]) |-> $past(s.dbc[0]) >= 16'(US_CYCLES - 1))
      else $error("zero debounce shorter than one microsecond");

   a_trig_cause: assert property (
      s.trig[0] && !$past(s.sw_pend[0]) |->
         $changed(s.filt[0]) && (s.filt[0] != $past(s.edge_fall[0])) && $past(s.src_en[0]))
      else $error("trigger without selected edge");

   a_plain_input: assert property (
      !$past(s.src_en[0]) && !$past(s.sw_pend[0]) |-> !s.trig[0])
      else $error("plain input produced trigger");

   a_sw_trigger: assert property (
      s.sw_pend[1] |=> s.trig[1])
      else $error("software trigger lost");

   a_frame_open: assert property (
      $past(s.pair_en[0]) && s.trig[0] |-> s.frame[0])
      else $error("first pulse did not open frame");

   a_frame_close: assert property (
      $past(s.pair_en[0]) && s.trig[1] && !s.trig[0] |-> !s.frame[0])
      else $error("second pulse did not close frame");

   a_frame_pair2: assert property (
      $past(s.pair_en[1]) && s.trig[2] |-> s.frame[1])
      else $error("third input did not open frame");

   a_irq_sticky: assert property (
      s.status[0] && !acc_rd_status |=> s.status[0])
      else $error("status bit lost");

   a_irq_level: assert property (
      ##1 (irq_o == |(s.status & s.mask)))
      else $error("interrupt level wrong");

   a_oe_gate: assert property (
      !$past(s.cfg[0][`TIO_C_OE]) |-> !gpo_oe_o[0])
      else $error("output driven without enable");

   a_strobe_start: assert property (
      (s.ph[0] == tio_pkg::ph_delay) && (s.cnt[0] == 16'h0000) && s.cfg[0][`TIO_C_MODE]
      |=> (s.ph[0] == tio_pkg::ph_pulse) && (gpo_o[0] != $past(s.cfg[0][`TIO_C_POL])))
      else $error("strobe pulse did not start");

   a_step_count: assert property (
      (s.ph[0] == tio_pkg::ph_pulse) && (s.cnt[0] != 16'h0000) && s.cfg[0][`TIO_C_MODE]
      |=> s.cnt[0] == $past(s.cnt[0]) - 16'h0001)
      else $error("pulse step not one clock");

   a_filt_follows: assert property (
      $changed(s.filt[0]) |-> s.filt[0] == $past(s.sync2[0]))
      else $error("debounced level not from synced input");

   a_level_write: assert property (
      acc_wr_level |=> level_sel_o == $past(wb_dat_i[7:0]))
      else $error("level select not written");

   a_static_out: assert property (
      !s.cfg[2][`TIO_C_MODE] |=> gpo_o[2] == $past(s.cfg[2][`TIO_C_STATIC]))
      else $error("static output level wrong");

   c_sw_trig: cover property (s.sw_pend[0] ##1 s.trig[0]);
   c_frame: cover property ($rose(s.frame[0]) ##[1:200] $fell(s.frame[0]));
   c_strobe: cover property (s.ph[0] == tio_pkg::ph_delay ##[1:50] s.ph[0] == tio_pkg::ph_pulse);
   c_irq: cover property ($rose(irq_o));

endmodule

`default_nettype wire

// >>> inc/tio_cfg.svh
// constants of the trigger input and strobe output block
// assumes a 40 MHz system clock and a byte-addressed classic Wishbone bus
`ifndef TIO_CFG_SVH
`define TIO_CFG_SVH

// --------------------------------------------------------------------
// sizes
// --------------------------------------------------------------------
`define TIO_N_IN        4
`define TIO_N_OUT       10
`define TIO_N_PAIR      2

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define TIO_CLK_MHZ     40
`define TIO_DB_UNIT_US  1
`define TIO_US_CYC      (`TIO_DB_UNIT_US * `TIO_CLK_MHZ)
`define TIO_STEP_NS     25

// --------------------------------------------------------------------
// register byte offsets; the two window selects are values of address bits 7:6
// --------------------------------------------------------------------
`define TIO_A_CTRL      8'h00
`define TIO_A_LEVEL     8'h04
`define TIO_A_DEBOUNCE  8'h08
`define TIO_A_SWTRIG    8'h0C
`define TIO_A_STATUS    8'h10
`define TIO_A_MASK      8'h14
`define TIO_A_INPUT     8'h18
`define TIO_A_CFG_WIN   2'h1
`define TIO_A_TIM_WIN   2'h2

// --------------------------------------------------------------------
// strobe config fields
// --------------------------------------------------------------------
`define TIO_C_OE        0
`define TIO_C_MODE      1
`define TIO_C_STATIC    2
`define TIO_C_POL       3
`define TIO_C_SRC_LO    4
`define TIO_C_SRC_HI    5
`define TIO_C_STB_EN    6

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define TIO_RST_REG     32'h0000_0000

`endif

// >>> inc/tio_pkg.sv
// types of the trigger input and strobe output block
// assumes tio_cfg.svh is on the include path
`include "tio_cfg.svh"

package tio_pkg;

   // strobe sequencer phase
   typedef enum logic [1:0] {
      ph_idle,
      ph_delay,
      ph_pulse
   } tio_phase_e;

   // whole state of the block
   typedef struct packed {
      logic [`TIO_N_IN-1:0]         sync1;
      logic [`TIO_N_IN-1:0]         sync2;
      logic [`TIO_N_IN-1:0]         filt;
      logic [`TIO_N_IN-1:0][15:0]   dbc;
      logic [`TIO_N_IN-1:0]         src_en;
      logic [`TIO_N_IN-1:0]         edge_fall;
      logic [`TIO_N_PAIR-1:0]       pair_en;
      logic [2*`TIO_N_IN-1:0]       lvl;
      logic [`TIO_N_IN-1:0][7:0]    dbv;
      logic [`TIO_N_IN-1:0]         sw_pend;
      logic [`TIO_N_IN-1:0]         trig;
      logic [`TIO_N_PAIR-1:0]       frame;
      logic [`TIO_N_IN-1:0]         status;
      logic [`TIO_N_IN-1:0]         mask;
      logic                         irq;
      logic [`TIO_N_OUT-1:0][6:0]   cfg;
      logic [`TIO_N_OUT-1:0][31:0]  tim;
      tio_phase_e [`TIO_N_OUT-1:0]  ph;
      logic [`TIO_N_OUT-1:0][15:0]  cnt;
      logic [`TIO_N_OUT-1:0]        gpo;
      logic [`TIO_N_OUT-1:0]        oe;
      logic                         ack;
      logic [31:0]                  dat;
   } tio_state_s;

endpackage

// >>> verification/tio_far_side.sv
// far side model: trigger sources on the input pins, load on the outputs
// assumes the bench clock; pins change just after a rising edge
`timescale 1ns/100ps
`default_nettype none
`include "tio_cfg.svh"
module tio_far_side (
   // clock
   input  wire logic                  sys_clk_i,
   // input pins driven by the sources
   output logic      [`TIO_N_IN-1:0]  pin_o,
   // output lines seen by the load
   input  wire logic [`TIO_N_OUT-1:0] gpo_i,
   input  wire logic [`TIO_N_OUT-1:0] oe_i
);
   // cycles each driven line sat high; undriven lines count nothing
   int hi_cnt [`TIO_N_OUT];

   initial pin_o = '0;

   // load samples only lines whose driver is enabled
   always @(posedge sys_clk_i) begin
      for (int j = 0; j < `TIO_N_OUT; j++) begin
         if (oe_i[j] === 1'b1 && gpo_i[j] === 1'b1) begin
            hi_cnt[j] <= hi_cnt[j] + 1;
         end
      end
   end

   // set one pin level just after an edge
   task automatic level(input int i, input logic v);
      @(posedge sys_clk_i);
      pin_o[i] <= v;
   endtask

   task automatic pulse(input int i, input int w);
      level(i, 1'b1);
      repeat (w - 1) @(posedge sys_clk_i);
      level(i, 1'b0);
   endtask
endmodule
`default_nettype wire

// >>> verification/trigger_input_and_strobe_io_bench.sv
// bench of the trigger input and strobe output block
// assumes the far side model and a 4 cycle microsecond in simulation
`timescale 1ns/100ps
`default_nettype none
`include "tio_cfg.svh"
module trigger_input_and_strobe_io_bench;
   logic        sys_clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, trig_in_i, trig_o;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        wb_ack_o, irq_o;
   logic [7:0]  level_sel_o;
   logic [1:0]  frame_active_o;
   logic [9:0]  gpo_o, gpo_oe_o;
   int          fails, checked, c, d, dl, du, t, g, lo, h0;
   logic [7:0]  r;

   tio_trigger_strobe #(.US_CYCLES(4)) DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .trig_in_i(trig_in_i), .level_sel_o(level_sel_o), .trig_o(trig_o),
      .frame_active_o(frame_active_o), .gpo_o(gpo_o), .gpo_oe_o(gpo_oe_o), .irq_o(irq_o));
   tio_far_side far (.sys_clk_i(sys_clk_i), .pin_o(trig_in_i), .gpo_i(gpo_o), .oe_i(gpo_oe_o));

   // clock, 25 ns period
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] gv, input logic [31:0] ev, input string m);
      checked++;
      if (gv !== ev) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, gv, ev);
      end
   endtask

   // one classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dv,
                     output logic [31:0] q);
      int k;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= dv;
      for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge sys_clk_i);
      if (k == 20) begin
         fails++;
         $display("unexpected at %0t: no ack", $time);
         final_report();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      logic [31:0] q;
      wb(1'b1, a, dv, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input string m);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, ev, m);
   endtask

   // count trigger pulses of input i over n cycles
   task automatic cnt(input int i, input int n, output int cv);
      cv = 0;
      repeat (n) begin
         @(negedge sys_clk_i);
         cv += int'(trig_o[i] === 1'b1);
      end
   endtask

   // pulse of w cycles on input i, expect n triggers
   task automatic pt(input int i, input int w, input int n, input string m);
      int cv;
      fork
         far.pulse(i, w);
         cnt(i, w + 40, cv);
      join
      chk(cv, n, m);
   endtask

   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'hF;
      fails = 0;
      checked = 0;
      reset_n_i = 1'b0;
      repeat (16) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      void'($urandom(35));
      rd(`TIO_A_CTRL, 32'h0, "ctrl reset");
      rd(`TIO_A_STATUS, 32'h0, "status reset");
      chk(gpo_oe_o, 10'h000, "outputs high-z");
      r = 8'($urandom);
      wr(`TIO_A_LEVEL, {24'h0, r});
      rd(`TIO_A_LEVEL, {24'h0, r}, "level read");
      chk(level_sel_o, r, "level out");
      rd(8'h1C, 32'h0, "unmapped read");
      $display("test registers done");
      wr(`TIO_A_CTRL, 32'h87);
      pt(0, 3, 0, "zero debounce short");
      pt(0, 6, 1, "zero debounce long");
      d = $urandom_range(1, 3);
      wr(`TIO_A_DEBOUNCE, 32'(d));
      pt(0, d * 4 - 1, 0, "short pulse");
      pt(0, d * 4 + 4, 1, "long pulse");
      wr(`TIO_A_DEBOUNCE, 32'hFF);
      pt(0, 1019, 0, "max debounce short");
      pt(0, 1030, 1, "max debounce long");
      $display("test debounce done");
      chk(irq_o, 1'b0, "masked irq");
      rd(`TIO_A_STATUS, 32'h1, "status sticky");
      wr(`TIO_A_DEBOUNCE, 32'h0);
      wr(`TIO_A_MASK, 32'h1);
      pt(0, 6, 1, "irq pulse");
      chk(irq_o, 1'b1, "irq raised");
      rd(`TIO_A_STATUS, 32'h1, "status again");
      chk(irq_o, 1'b0, "irq cleared");
      far.level(3, 1'b1);
      repeat (20) @(negedge sys_clk_i);
      rd(`TIO_A_INPUT, 32'h8, "input level");
      rd(`TIO_A_STATUS, 32'h0, "no rising event");
      fork
         far.level(3, 1'b0);
         cnt(3, 30, c);
      join
      chk(c, 0, "plain input");
      rd(`TIO_A_STATUS, 32'h8, "falling event");
      $display("test events done");
      fork
         wr(`TIO_A_SWTRIG, 32'h4);
         cnt(2, 20, c);
      join
      chk(c, 1, "software trigger");
      wr(`TIO_A_CTRL, 32'h387);
      for (int p = 0; p < 2; p++) begin
         wr(`TIO_A_SWTRIG, 32'(1 << (2 * p)));
         repeat (3) @(negedge sys_clk_i);
         chk(frame_active_o[p], 1'b1, "frame open");
         wr(`TIO_A_SWTRIG, 32'(2 << (2 * p)));
         repeat (3) @(negedge sys_clk_i);
         chk(frame_active_o[p], 1'b0, "frame closed");
      end
      $display("test pairs done");
      dl = $urandom_range(1, 8);
      du = $urandom_range(1, 8);
      wr(8'h80, {16'(du), 16'(dl)});
      wr(8'h40, 32'h43);
      wr(8'h44, 32'h4B);
      wr(8'h48, 32'h05);
      @(negedge sys_clk_i);
      chk(gpo_oe_o, 10'h007, "enabled drivers");
      chk(gpo_o[2:1], 2'b11, "static and idle");
      h0 = far.hi_cnt[0];
      t = -1;
      g = -1;
      lo = 0;
      fork
         wr(`TIO_A_SWTRIG, 32'h1);
         for (int k = 0; k < 60; k++) begin
            @(negedge sys_clk_i);
            if (trig_o[0] === 1'b1) t = k;
            if (gpo_o[0] === 1'b1 && g < 0) g = k;
            lo += int'(gpo_o[1] === 1'b0);
         end
      join
      chk(g - t, dl + 2, "strobe delay");
      chk(far.hi_cnt[0] - h0, du + 1, "strobe width");
      chk(lo, 1, "active low strobe");
      $display("test strobes done");
      final_report();
   end
endmodule
`default_nettype wire
